// *** motor_stage_model.sv ***
// model: motor and power stage finishing each step after a settle time
`timescale 1ns/1ps
module motor_stage_model #(
  parameter int SETTLE = 12
) (
  // clock, reset, step requests
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] step_i,
  // completion pulse and rest flag
  output logic            done_o,
  output logic            idle_o
);
  logic [7:0] cnt_reg;
  // motor rests only while nothing drives it
  assign idle_o = (step_i == 5'h00);
  // one-cycle pulse; count restarts so a lagging step is not ended twice
  always @(posedge clk_i) begin
    done_o  <= (cnt_reg == 8'(SETTLE)) && !rst_i;
    cnt_reg <= (rst_i || step_i == 5'h00 || done_o) ? 8'h00 : cnt_reg + 8'h01;
  end
endmodule // motor_stage_model

// *** param_measure_pkg.sv ***
// package: register map, field layout, constants and types of the measurement sequencer
package param_measure_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] TARGET_OFS   = 8'h04;
  localparam logic [7:0] DETECT_OFS   = 8'h08;
  localparam logic [7:0] OL_OFS       = 8'h0C;
  localparam logic [7:0] NORMAL_OFS   = 8'h10;
  localparam logic [7:0] LIMITS_OFS   = 8'h14;
  localparam logic [7:0] PWM_OFS      = 8'h18;
  localparam logic [7:0] NV_PAR_OFS   = 8'h1C;
  localparam logic [7:0] NV_GAIN_OFS  = 8'h20;
  localparam logic [7:0] STATUS_OFS   = 8'h24;
  localparam logic [7:0] RESULT_OFS   = 8'h28;
  localparam logic [7:0] SHADOW_OFS   = 8'h2C;
  localparam logic [7:0] SH_GAIN_OFS  = 8'h30;

  // ----------------------------------------------------------------
  // control and status register bit positions
  // ----------------------------------------------------------------
  localparam int CMD_BIT        = 0;
  localparam int RES_EN_BIT     = 1;
  localparam int IND_EN_BIT     = 2;
  localparam int KE_EN_BIT      = 3;
  localparam int MECH_EN_BIT    = 4;
  localparam int DET_SEL_BIT    = 5;
  localparam int OL_SEL_BIT     = 6;
  localparam int SURGE_EN_BIT   = 7;
  localparam int WR_SHADOW_BIT  = 8;
  localparam int DET_FAULT_BIT  = 4;
  localparam int BEMF_FAULT_BIT = 5;

  // ----------------------------------------------------------------
  // reset values, limits and scale factors
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [6:0]  PWM_MIN_KHZ  = 7'd10;
  localparam logic [6:0]  PWM_MAX_KHZ  = 7'd75;
  localparam logic [6:0]  PWM_RST_KHZ  = 7'd20;
  localparam logic [15:0] OL_CUR_NUM   = 16'd4;   // 80 % = 4/5
  localparam logic [15:0] OL_CUR_DEN   = 16'd5;
  localparam int          DECAY_FACTOR = 3;
  localparam int          CUR_BW_SHIFT = 2;       // current loop bandwidth scale
  localparam int          SPD_BW_SHIFT = 1;       // speed loop bandwidth scale

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DETECT, ST_OPEN_LOOP, ST_RAMP_DOWN, ST_COAST, ST_STARTUP
  } seq_state_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] ind;
    logic [7:0] ke;
  } motor_par_t;

  typedef struct packed {
    logic [7:0] cur_kp;
    logic [7:0] cur_ki;
    logic [7:0] spd_kp;
    logic [7:0] spd_ki;
  } loop_gain_t;

  typedef struct packed {
    logic [7:0]  slew_one;
    logic [7:0]  slew_two;
    logic [7:0]  current_ref;
    logic [15:0] speed_ref;
  } ol_ref_t;

  typedef struct packed {
    logic [7:0] current_limit;
    logic [3:0] repeat_count;
  } detect_cfg_t;

endpackage : param_measure_pkg

// *** param_measure_seq.sv ***
// design: offline motor parameter measurement sequencer with wishbone registers
`timescale 1ns/1ps

// Function
// R01: enter routine on command bit set or non-zero target speed.
// R02: four steps in fixed order, each skipped when its condition is false.
// R03: leave routine after last step; start up if target speed non-zero.
// R04: detection runs when R or L measured, or configured R or L is zero.
// R05: detection source select picks measurement or normal current limit and repeat.
// R06: detection fault on timer overflow or decay above three times ramp-up.
// R07: align and open-loop acceleration run when back-EMF or mechanical measured.
// R08: zero speed-loop gains force mechanical measurement on.
// R09: open-loop source select high uses measurement slew, current and speed refs.
// R10: select low uses normal slew, 80% current limit, 50% maximum speed.
// R11: current ramp-down only while mechanical measurement is active.
// R12: final step puts outputs high impedance and measures while coasting.
// R13: back-EMF fault when coasting back-EMF below stationary threshold.
// R14: results readable; write-shadow bit copies estimates into seven shadows. The friction estimate is not readable.
// R15: a zero non-volatile shadow value uses the estimate regardless.
// R16: current-loop gains derived from measured resistance and inductance.
// R17: speed-loop gains derived from estimated inertia and friction.
// R18: surge guard follows its enable bit.
// R19: guard disabled: deceleration follows the closed-loop decel field.
// R20: output switching frequency selectable from 10 to 75 kHz.
// R21: command and target sampled only when idle; entry latched until exit.
module param_measure_seq
  import param_measure_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [7:0]                    adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // measurement engine status
  input  wire logic                          motor_idle_i,
  input  wire logic                          step_done_i,
  input  wire logic                          detect_timer_ovf_i,
  input  wire logic [15:0]                   decay_time_i,
  input  wire logic [15:0]                   rampup_time_i,
  input  wire logic [7:0]                    coast_bemf_i,
  input  wire param_measure_pkg::motor_par_t est_par_i,
  input  wire logic [7:0]                    est_inertia_i,
  input  wire logic [7:0]                    est_friction_i,
  // step control to power stage
  output logic                               detect_run_o,
  output logic                               open_loop_run_o,
  output logic                               ramp_down_run_o,
  output logic                               outputs_hiz_o,
  output logic                               startup_run_o,
  output logic [15:0]                        startup_speed_o,
  output param_measure_pkg::detect_cfg_t     detect_cfg_o,
  output param_measure_pkg::ol_ref_t         ol_ref_o,
  // active motor parameters and gains
  output param_measure_pkg::motor_par_t      active_par_o,
  output param_measure_pkg::loop_gain_t      active_gain_o,
  // supply and switching control
  output logic                               surge_guard_o,
  output logic [3:0]                         decel_rate_o,
  output logic [6:0]                         switching_freq_o
);
  import param_measure_pkg::*;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t  state;
    logic        entry_latched;
    logic        mech_latched;
    logic [31:0] ctrl;
    logic [15:0] target;
    logic [23:0] detect_cfg;
    logic [31:0] ol_cfg;
    logic [23:0] normal_cfg;
    logic [27:0] limits;
    logic [6:0]  pwm_khz;
    motor_par_t  nv_par;
    loop_gain_t  nv_gain;
    motor_par_t  sh_par;
    loop_gain_t  sh_gain;
    motor_par_t  est_par;
    logic [7:0]  est_inertia;
    logic [7:0]  est_friction;
    logic        detect_fault;
    logic        bemf_fault;
    logic        ack;
    logic [31:0] rdata;
    logic        detect_run;
    logic        open_loop_run;
    logic        ramp_down_run;
    logic        outputs_hiz;
    logic        startup_run;
    logic [15:0] startup_speed;
    detect_cfg_t det_out;
    ol_ref_t     ol_out;
    motor_par_t  act_par;
    loop_gain_t  act_gain;
    logic        surge;
    logic [3:0]  decel;
    logic [6:0]  freq;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;

  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  logic        mech_active;
  logic        detect_needed;
  logic        ol_needed;
  logic [15:0] ilim_80;
  logic [15:0] decay_limit;
  loop_gain_t  est_gain;
  motor_par_t  eff_par;
  loop_gain_t  eff_gain;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] wmask;

  // step entry conditions, evaluated from live configuration
  always_comb begin
    mech_active   = r_reg.ctrl[MECH_EN_BIT]
                  | (r_reg.nv_gain.spd_kp == 8'h00 && r_reg.nv_gain.spd_ki == 8'h00); // R08
    detect_needed = r_reg.ctrl[RES_EN_BIT] | r_reg.ctrl[IND_EN_BIT]
                  | (r_reg.nv_par.res == 8'h00) | (r_reg.nv_par.ind == 8'h00);        // R04
    ol_needed     = r_reg.ctrl[KE_EN_BIT] | mech_active;                              // R07
    ilim_80       = 16'((16'(r_reg.normal_cfg[23:16]) * OL_CUR_NUM) / OL_CUR_DEN);    // R10
    decay_limit   = 16'(rampup_time_i * 16'(DECAY_FACTOR));
  end

  // gains from estimates; one shift per loop keeps the math cheap
  always_comb begin
    est_gain.cur_kp = 8'(r_reg.est_par.ind << CUR_BW_SHIFT);    // R16
    est_gain.cur_ki = 8'(r_reg.est_par.res << CUR_BW_SHIFT);    // R16
    est_gain.spd_kp = 8'(r_reg.est_inertia << SPD_BW_SHIFT);    // R17
    est_gain.spd_ki = 8'(r_reg.est_friction << SPD_BW_SHIFT);   // R17
  end

  // a zero loaded from storage falls through to the estimate
  always_comb begin
    eff_par.res     = (r_reg.nv_par.res == 8'h00) ? r_reg.est_par.res : r_reg.sh_par.res; // R15
    eff_par.ind     = (r_reg.nv_par.ind == 8'h00) ? r_reg.est_par.ind : r_reg.sh_par.ind; // R15
    eff_par.ke      = (r_reg.nv_par.ke == 8'h00) ? r_reg.est_par.ke : r_reg.sh_par.ke;    // R15
    eff_gain.cur_kp = (r_reg.nv_gain.cur_kp == 8'h00) ? est_gain.cur_kp
                                                       : r_reg.sh_gain.cur_kp;            // R15
    eff_gain.cur_ki = (r_reg.nv_gain.cur_ki == 8'h00) ? est_gain.cur_ki
                                                       : r_reg.sh_gain.cur_ki;            // R15
    eff_gain.spd_kp = (r_reg.nv_gain.spd_kp == 8'h00) ? est_gain.spd_kp
                                                       : r_reg.sh_gain.spd_kp;            // R15
    eff_gain.spd_ki = (r_reg.nv_gain.spd_ki == 8'h00) ? est_gain.spd_ki
                                                       : r_reg.sh_gain.spd_ki;            // R15
  end

  // byte-lane mask from wishbone select
  always_comb begin
    wb_req = cyc_i & stb_i & ~r_reg.ack;
    wb_wr  = wb_req & we_i;
    wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next      = r_reg;
    r_next.ack  = wb_req;

    // register writes; settings stay writable while running, steps read them live
    if (wb_wr) begin
      unique case (adr_i)
        CTRL_OFS:    r_next.ctrl = (r_reg.ctrl & ~wmask) | (dat_i & wmask);
        TARGET_OFS:  r_next.target = 16'((32'(r_reg.target) & ~wmask) | (dat_i & wmask));
        DETECT_OFS:  r_next.detect_cfg = 24'((32'(r_reg.detect_cfg) & ~wmask) | (dat_i & wmask));
        OL_OFS:      r_next.ol_cfg = (r_reg.ol_cfg & ~wmask) | (dat_i & wmask);
        NORMAL_OFS:  r_next.normal_cfg = 24'((32'(r_reg.normal_cfg) & ~wmask) | (dat_i & wmask));
        LIMITS_OFS:  r_next.limits = 28'((32'(r_reg.limits) & ~wmask) | (dat_i & wmask));
        PWM_OFS: begin
          if (sel_i[0]) begin
            // out-of-range requests are clamped into the supported band
            if (dat_i[6:0] < PWM_MIN_KHZ) r_next.pwm_khz = PWM_MIN_KHZ;       // R20
            else if (dat_i[6:0] > PWM_MAX_KHZ) r_next.pwm_khz = PWM_MAX_KHZ;  // R20
            else r_next.pwm_khz = dat_i[6:0];                                 // R20
          end
        end
        NV_PAR_OFS: begin
          r_next.nv_par = 24'((32'(r_reg.nv_par) & ~wmask) | (dat_i & wmask));
          r_next.sh_par = r_next.nv_par;
        end
        NV_GAIN_OFS: begin
          r_next.nv_gain = (r_reg.nv_gain & ~wmask) | (dat_i & wmask);
          r_next.sh_gain = r_next.nv_gain;
        end
        STATUS_OFS: begin
          // write one to clear; a fault raised below in this cycle wins
          if (sel_i[0] && dat_i[DET_FAULT_BIT]) r_next.detect_fault = 1'b0;
          if (sel_i[0] && dat_i[BEMF_FAULT_BIT]) r_next.bemf_fault = 1'b0;
        end
        default: ;
      endcase
    end

    r_next.ctrl[WR_SHADOW_BIT] = 1'b0;   // write-shadow is a strobe, never stored

    // copy estimates into all seven shadows on request
    if (wb_wr && adr_i == CTRL_OFS && sel_i[1] && dat_i[WR_SHADOW_BIT]) begin
      r_next.sh_par  = r_reg.est_par;   // R14
      r_next.sh_gain = est_gain;        // R14
    end

    // register reads
    r_next.rdata = 32'h0000_0000;
    if (wb_req && !we_i) begin
      unique case (adr_i)
        CTRL_OFS:    r_next.rdata = r_reg.ctrl;
        TARGET_OFS:  r_next.rdata = {16'h0000, r_reg.target};
        DETECT_OFS:  r_next.rdata = {8'h00, r_reg.detect_cfg};
        OL_OFS:      r_next.rdata = r_reg.ol_cfg;
        NORMAL_OFS:  r_next.rdata = {8'h00, r_reg.normal_cfg};
        LIMITS_OFS:  r_next.rdata = {4'h0, r_reg.limits};
        PWM_OFS:     r_next.rdata = {25'h0, r_reg.pwm_khz};
        NV_PAR_OFS:  r_next.rdata = {8'h00, r_reg.nv_par};
        NV_GAIN_OFS: r_next.rdata = r_reg.nv_gain;
        STATUS_OFS:  r_next.rdata = {26'h0, r_reg.bemf_fault, r_reg.detect_fault,
                                     r_reg.entry_latched, r_reg.state};
        RESULT_OFS:  r_next.rdata = {r_reg.est_par, r_reg.est_inertia};   // R14
        SHADOW_OFS:  r_next.rdata = {8'h00, eff_par};
        SH_GAIN_OFS: r_next.rdata = eff_gain;
        default:     r_next.rdata = 32'h0000_0000;
      endcase
    end

    // sequencer
    unique case (r_reg.state)
      ST_IDLE: begin
        // sample command and target only at rest, then hold the decision
        if (motor_idle_i && (r_reg.ctrl[CMD_BIT] || r_reg.target != 16'h0000)) begin // R01 R21
          r_next.entry_latched    = 1'b1;                                            // R21
          r_next.mech_latched     = mech_active;
          r_next.ctrl[CMD_BIT]    = 1'b0;
          if (detect_needed) r_next.state = ST_DETECT;                               // R02
          else if (ol_needed) r_next.state = ST_OPEN_LOOP;                           // R02
          else r_next.state = ST_COAST;                                              // R02
        end
      end
      ST_DETECT: begin
        if (detect_timer_ovf_i || step_done_i) begin
          r_next.est_par.res = est_par_i.res;
          r_next.est_par.ind = est_par_i.ind;
          if (detect_timer_ovf_i || decay_time_i > decay_limit)
            r_next.detect_fault = 1'b1;                                              // R06
          r_next.state = ol_needed ? ST_OPEN_LOOP : ST_COAST;                        // R02 R07
        end
      end
      ST_OPEN_LOOP: begin
        if (step_done_i)
          r_next.state = r_reg.mech_latched ? ST_RAMP_DOWN : ST_COAST;               // R11
      end
      ST_RAMP_DOWN: begin
        if (step_done_i) r_next.state = ST_COAST;                                    // R02
      end
      ST_COAST: begin
        if (step_done_i) begin
          r_next.est_par.ke   = est_par_i.ke;
          r_next.est_inertia  = est_inertia_i;
          r_next.est_friction = est_friction_i;
          if (coast_bemf_i < r_reg.limits[23:16]) r_next.bemf_fault = 1'b1;          // R13
          r_next.entry_latched = 1'b0;
          r_next.state = (r_reg.target != 16'h0000) ? ST_STARTUP : ST_IDLE;          // R03
        end
      end
      ST_STARTUP: begin
        // normal drive until the speed command returns to zero
        if (r_reg.target == 16'h0000) r_next.state = ST_IDLE;                        // R03
      end
    endcase

    // step outputs follow the next state so they align with it
    r_next.detect_run    = (r_next.state == ST_DETECT);
    r_next.open_loop_run = (r_next.state == ST_OPEN_LOOP);
    r_next.ramp_down_run = (r_next.state == ST_RAMP_DOWN);                           // R11
    r_next.outputs_hiz   = (r_next.state == ST_COAST);                               // R12
    r_next.startup_run   = (r_next.state == ST_STARTUP);                             // R03
    r_next.startup_speed = r_next.startup_run ? r_reg.target : 16'h0000;

    // detection limits from the selected source
    if (r_reg.ctrl[DET_SEL_BIT]) begin
      r_next.det_out.current_limit = r_reg.detect_cfg[7:0];                          // R05
      r_next.det_out.repeat_count  = r_reg.detect_cfg[11:8];                         // R05
    end else begin
      r_next.det_out.current_limit = r_reg.detect_cfg[19:12];                        // R05
      r_next.det_out.repeat_count  = r_reg.detect_cfg[23:20];                        // R05
    end

    // open-loop references from the selected source
    if (r_reg.ctrl[OL_SEL_BIT]) begin
      r_next.ol_out.slew_one    = r_reg.ol_cfg[7:0];                                 // R09
      r_next.ol_out.slew_two    = 8'h00;                                             // R09
      r_next.ol_out.current_ref = r_reg.ol_cfg[15:8];                                // R09
      r_next.ol_out.speed_ref   = r_reg.ol_cfg[31:16];                               // R09
    end else begin
      r_next.ol_out.slew_one    = r_reg.normal_cfg[7:0];                             // R10
      r_next.ol_out.slew_two    = r_reg.normal_cfg[15:8];                            // R10
      r_next.ol_out.current_ref = ilim_80[7:0];                                      // R10
      r_next.ol_out.speed_ref   = {1'b0, r_reg.limits[15:1]};                        // R10
    end

    // parameters and gains handed to the control loops
    r_next.act_par  = eff_par;
    r_next.act_gain = eff_gain;

    // surge guard and deceleration rate
    r_next.surge = r_reg.ctrl[SURGE_EN_BIT];                                         // R18
    r_next.decel = r_reg.ctrl[SURGE_EN_BIT] ? 4'h0 : r_reg.limits[27:24];            // R19
    r_next.freq  = r_reg.pwm_khz;                                                    // R20
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg         <= '0;
      r_reg.state   <= ST_IDLE;
      r_reg.ctrl    <= CTRL_RST;
      r_reg.pwm_khz <= PWM_RST_KHZ;
      r_reg.freq    <= PWM_RST_KHZ;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign dat_o            = r_reg.rdata;
  assign ack_o            = r_reg.ack;
  assign detect_run_o     = r_reg.detect_run;
  assign open_loop_run_o  = r_reg.open_loop_run;
  assign ramp_down_run_o  = r_reg.ramp_down_run;
  assign outputs_hiz_o    = r_reg.outputs_hiz;
  assign startup_run_o    = r_reg.startup_run;
  assign startup_speed_o  = r_reg.startup_speed;
  assign detect_cfg_o     = r_reg.det_out;
  assign ol_ref_o         = r_reg.ol_out;
  assign active_par_o     = r_reg.act_par;
  assign active_gain_o    = r_reg.act_gain;
  assign surge_guard_o    = r_reg.surge;
  assign decel_rate_o     = r_reg.decel;
  assign switching_freq_o = r_reg.freq;

endmodule // param_measure_seq

// *** param_measure_seq_bench.sv ***
// testbench: register-driven measurement runs against a motor model
`timescale 1ns/1ps
module param_measure_seq_bench;
  import param_measure_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        ack_o, motor_idle_i, step_done_i, detect_timer_ovf_i = 1'b0;
  logic        detect_run_o, open_loop_run_o, ramp_down_run_o, outputs_hiz_o;
  logic        startup_run_o, surge_guard_o;
  logic [3:0]  sel_i = 4'hF, decel_rate_o;
  logic [6:0]  switching_freq_o;
  logic [7:0]  adr_i = 8'h00, coast_bemf_i = 8'h50, est_inertia_i = 8'h08;
  logic [7:0]  est_friction_i = 8'h10;
  logic [15:0] decay_time_i = 16'h0030, rampup_time_i = 16'h0010, startup_speed_o;
  logic [15:0] pw [4] = '{16'h090A, 16'h4B4B, 16'h4C4B, 16'h3333};
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  motor_par_t  est_par_i = 24'h44_5566, active_par_o;
  loop_gain_t  active_gain_o;
  detect_cfg_t detect_cfg_o;
  ol_ref_t     ol_ref_o;
  int          fails = 0, check_count = 0;
  // 125 MHz
  always #4 clk_i = ~clk_i;
  param_measure_seq param_measure_seq_i (.*);
  motor_stage_model motor_stage_model_i (.clk_i(clk_i), .rst_i(rst_i), .done_o(step_done_i),
    .step_i({startup_run_o, outputs_hiz_o, ramp_down_run_o, open_loop_run_o, detect_run_o}),
    .idle_o(motor_idle_i));
  // --------------------
  // bus and check tasks
  // --------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask
  // polls status until the sequencer reaches a state
  task automatic wait_st(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      wb(1'b0, STATUS_OFS, 32'h0);
      n++;
    end while (rd[2:0] !== st && n < 200);
    if (n >= 200) begin
      fails++;
      summarize();
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(switching_freq_o, 7'h14);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, PWM_OFS, {24'h0, pw[i][15:8]});
      wb(1'b0, PWM_OFS, 32'h0);
      chk(rd, {24'h0, pw[i][7:0]});
      chk(switching_freq_o, pw[i][6:0]);
    end
    wb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, LIMITS_OFS, 32'h0940_1000);
    wb(1'b1, CTRL_OFS, 32'h80);
    chk({surge_guard_o, decel_rate_o}, 5'h10);
    wb(1'b1, CTRL_OFS, 32'h0);
    chk({surge_guard_o, decel_rate_o}, 5'h09);
    wb(1'b1, DETECT_OFS, 32'h0067_735A);
    wb(1'b1, OL_OFS, 32'h5678_3412);
    wb(1'b1, NORMAL_OFS, 32'h0064_4321);
    wb(1'b1, NV_PAR_OFS, 32'h0011_2233);
    wb(1'b1, NV_GAIN_OFS, 32'h0102_0304);
    // full run by command, measurement-specific sources
    wb(1'b1, CTRL_OFS, 32'h7F);
    wait_st(3'h1);
    chk(detect_cfg_o, 12'h5A3);
    wait_st(3'h2);
    chk(ol_ref_o, 40'h12_00_34_5678);
    wait_st(3'h3);
    wait_st(3'h4);
    chk(outputs_hiz_o, 1'b1);
    wait_st(3'h0);
    chk(rd[5:4], 2'b00);
    wb(1'b0, RESULT_OFS, 32'h0);
    chk(rd, 32'h4455_6608);
    wb(1'b0, SHADOW_OFS, 32'h0);
    chk(rd, 32'h0011_2233);
    wb(1'b1, CTRL_OFS, 32'h100);
    chk(active_par_o, 24'h44_5566);
    chk(active_gain_o, 32'h5410_1020);
    // run by target speed, normal sources, weak coast back-EMF
    coast_bemf_i <= 8'h3F;
    wb(1'b1, CTRL_OFS, 32'h08);
    wb(1'b1, TARGET_OFS, 32'h0000_0ABC);
    wait_st(3'h2);
    chk(ol_ref_o, 40'h21_43_50_0800);
    wait_st(3'h5);
    chk({startup_run_o, startup_speed_o}, 17'h1_0ABC);
    chk(rd[5:4], 2'b10);
    wb(1'b1, TARGET_OFS, 32'h0);
    wait_st(3'h0);
    wb(1'b1, STATUS_OFS, 32'h30);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    // detection only, normal source, slow current decay
    coast_bemf_i <= 8'h50;
    decay_time_i <= 16'h0031;
    wb(1'b1, CTRL_OFS, 32'h03);
    wait_st(3'h1);
    chk(detect_cfg_o, 12'h776);
    wait_st(3'h0);
    chk(rd, 32'h10);
    // timer overflow ends detection at once with a fault
    wb(1'b1, STATUS_OFS, 32'h30);
    {decay_time_i, detect_timer_ovf_i} <= {16'h0030, 1'b1};
    wb(1'b1, CTRL_OFS, 32'h03);
    wait_st(3'h0);
    chk(rd, 32'h10);
    // zero stored resistance reads as estimate; zero speed gains force ramp-down
    detect_timer_ovf_i <= 1'b0;
    wb(1'b1, NV_PAR_OFS, 32'h0000_2233);
    wb(1'b0, SHADOW_OFS, 32'h0);
    chk(rd, 32'h0044_2233);
    wb(1'b1, NV_GAIN_OFS, 32'h0102_0000);
    wb(1'b1, CTRL_OFS, 32'h01);
    wait_st(3'h3);
    wait_st(3'h0);
    summarize();
  end
endmodule // param_measure_seq_bench

// *** param_measure_seq_props.sv ***
// checker: step order and output relations of the sequencer
`timescale 1ns/1ps
module param_measure_seq_props (
  // clock, reset, engine status
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        step_done_i,
  input wire logic        detect_timer_ovf_i,
  // step and control outputs
  input wire logic        detect_run_o,
  input wire logic        open_loop_run_o,
  input wire logic        ramp_down_run_o,
  input wire logic        outputs_hiz_o,
  input wire logic        startup_run_o,
  input wire logic [15:0] startup_speed_o,
  input wire logic        surge_guard_o,
  input wire logic [3:0]  decel_rate_o,
  input wire logic [6:0]  switching_freq_o
);
  logic [4:0] step;
  logic       det_end;
  // --------------------
  // output properties
  // --------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // step vector, and what may end detection
  assign step = {startup_run_o, outputs_hiz_o, ramp_down_run_o, open_loop_run_o, detect_run_o};
  assign det_end = step_done_i | detect_timer_ovf_i;
  // steps end one or two cycles after their cause: register lag allowed
  property p_one_step; $onehot0(step); endproperty
  a_one_step: assert property (p_one_step) else $error("steps overlap");
  property p_freq_span; switching_freq_o inside {[7'h0A:7'h4B]}; endproperty
  a_freq_span: assert property (p_freq_span) else $error("frequency out of span");
  property p_guard_decel; surge_guard_o |-> decel_rate_o == 4'h0; endproperty
  a_guard_decel: assert property (p_guard_decel) else $error("decel with guard on");
  property p_idle_speed; !startup_run_o |-> startup_speed_o == 16'h0000; endproperty
  a_idle_speed: assert property (p_idle_speed) else $error("speed outside startup");
  property p_ramp_order; $rose(ramp_down_run_o) |-> $past(open_loop_run_o); endproperty
  a_ramp_order: assert property (p_ramp_order) else $error("ramp not after accel");
  property p_detect_end; $fell(detect_run_o) |-> $past(det_end) || $past(det_end, 2); endproperty
  a_detect_end: assert property (p_detect_end) else $error("detect ended early");
  property p_coast_end;
    $fell(outputs_hiz_o) |-> $past(step_done_i) || $past(step_done_i, 2);
  endproperty
  a_coast_end: assert property (p_coast_end) else $error("coast ended early");
  property p_start_order; $rose(startup_run_o) |-> $past(outputs_hiz_o); endproperty
  a_start_order: assert property (p_start_order) else $error("startup not after coast");
endmodule // param_measure_seq_props
bind param_measure_seq param_measure_seq_props param_measure_seq_props_i (.*);
